// ===== logic/coil_focus_drive_control.sv
// mode sequencer, setpoint ramp and output stage control for the focus coil
`timescale 1ns/100ps

module coil_focus_drive_control #(
    parameter int SCL_TIMEOUT_CYC = coil_focus_pkg::SCL_TIMEOUT_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_scl,
    input wire logic i_overtemp_fault,
    input wire logic i_coil_short_fault,
    input wire logic i_coil_open_fault,
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    output logic [1:0] o_power_state,
    output logic o_stage_en,
    output logic o_pwm_mode,
    output logic o_hs_on,
    output logic o_ls_on,
    output logic [9:0] o_dac_code
);

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [3:0] sync_a;
    logic [3:0] sync_b;
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            sync_a <= 4'h1;
            sync_b <= 4'h1;
        end
        else if (i_ce)
        begin
            sync_a <= {i_coil_open_fault, i_coil_short_fault, i_overtemp_fault, i_scl};
            sync_b <= sync_a;
        end
    end
    wire logic scl_s = sync_b[0];
    wire logic any_fault = |sync_b[3:1];

    // ****************************************
    // state and registers
    // ****************************************
    coil_focus_pkg::power_state_t state;
    logic [23:0] low_cnt;
    logic [2:0] control;
    logic pwm_mode;
    logic [1:0] setpoint_hi;
    logic [9:0] setpoint;
    logic [7:0] res_freq;
    logic [9:0] ramp_start;
    logic [6:0] ramp_step;
    logic [19:0] ramp_acc;
    logic ramp_busy;
    logic [5:0] pwm_cnt;

    // register write decode; the pin-low timeout blocks all writes
    wire logic wr_ok = i_reg_wr && (state != coil_focus_pkg::ST_SHUTDOWN);
    wire logic wr_ctrl = wr_ok && (i_reg_addr == coil_focus_pkg::ADDR_CONTROL);
    wire logic wr_hi = wr_ok && (i_reg_addr == coil_focus_pkg::ADDR_SETPOINT_HI);
    wire logic wr_lo = wr_ok && (i_reg_addr == coil_focus_pkg::ADDR_SETPOINT_LO);
    wire logic wr_mode = wr_ok && (i_reg_addr == coil_focus_pkg::ADDR_MODE);
    wire logic wr_freq = wr_ok && (i_reg_addr == coil_focus_pkg::ADDR_RES_FREQ);
    wire logic soft_rst = wr_ctrl && i_reg_wdata[coil_focus_pkg::CTRL_SOFT_RESET_BIT];
    // the low byte commits the full 10-bit code so both halves change together
    wire logic [9:0] new_setpoint = {setpoint_hi, i_reg_wdata};
    wire logic timeout = !scl_s && (low_cnt >= 24'(SCL_TIMEOUT_CYC - 1));
    wire logic fault_hit = any_fault && (state == coil_focus_pkg::ST_ACTIVE);
    wire logic load_defaults = soft_rst || fault_hit ||
        ((state == coil_focus_pkg::ST_SHUTDOWN) && scl_s);

    // resonance frequency in Hz from the code: count table entries not above it
    logic [7:0] res_hz;
    always_comb
    begin
        res_hz = coil_focus_pkg::RES_BASE_HZ;
        for (int i = 1; i <= 100; i++)
        begin
            if (coil_focus_pkg::RES_CODE_TABLE[i] <= res_freq)
            begin
                res_hz = res_hz + 8'h01;
            end
        end
    end

    // ramp pacing: step advances each time the summed frequency passes the threshold
    // control packs the two-period bit at its bit 0, below the pwm field
    wire logic [19:0] ramp_thresh = control[0] ?
        coil_focus_pkg::RAMP_THRESH_2P : coil_focus_pkg::RAMP_THRESH_1P;
    wire logic [19:0] acc_sum = ramp_acc + {12'h000, res_hz};
    wire logic step_tick = acc_sum >= ramp_thresh;
    wire logic [19:0] next_acc = step_tick ? acc_sum - ramp_thresh : acc_sum;
    wire logic [6:0] next_step = ramp_step + 7'h01;
    wire logic ramp_done = step_tick && (next_step == coil_focus_pkg::RAMP_STEPS);

    // linear interpolation between the ramp start and the target
    wire logic signed [11:0] ramp_diff = $signed({2'b00, setpoint}) - $signed({2'b00, ramp_start});
    wire logic signed [19:0] ramp_prod = ramp_diff * $signed({1'b0, next_step});
    wire logic [11:0] ramp_sum = {2'b00, ramp_start} +
        ramp_prod[coil_focus_pkg::RAMP_STEP_BITS +: 12];
    wire logic [9:0] next_dac = ramp_done ? setpoint : ramp_sum[9:0];

    // ****************************************
    // power state sequencer
    // ****************************************
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            state <= coil_focus_pkg::ST_STANDBY;
            low_cnt <= 24'h000000;
        end
        else if (i_ce)
        begin
            low_cnt <= scl_s ? 24'h000000 : (timeout ? low_cnt : low_cnt + 24'h000001);
            if (timeout)
            begin
                state <= coil_focus_pkg::ST_SHUTDOWN;
            end
            else if (load_defaults)
            begin
                state <= coil_focus_pkg::ST_STANDBY;
            end
            else if (state != coil_focus_pkg::ST_SHUTDOWN)
            begin
                if (wr_lo)
                begin
                    state <= (new_setpoint != 10'h000) ? coil_focus_pkg::ST_ACTIVE
                        : coil_focus_pkg::ST_STANDBY;
                end
            end
        end
    end

    // ****************************************
    // register file
    // ****************************************
    always_ff @(posedge i_clk)
    begin
        if (i_rst || (i_ce && (load_defaults || timeout)))
        begin
            control <= coil_focus_pkg::CONTROL_RESET;
            pwm_mode <= coil_focus_pkg::MODE_RESET;
            setpoint_hi <= 2'h0;
            setpoint <= coil_focus_pkg::SETPOINT_RESET;
            res_freq <= coil_focus_pkg::RES_FREQ_RESET;
        end
        else if (i_ce)
        begin
            // soft reset bit never stores, so it reads back as zero
            if (wr_ctrl)
            begin
                control <= {i_reg_wdata[3:2], i_reg_wdata[coil_focus_pkg::CTRL_TWO_PERIOD_BIT]};
            end
            if (wr_mode)
            begin
                pwm_mode <= i_reg_wdata[coil_focus_pkg::MODE_PWM_BIT];
            end
            if (wr_hi)
            begin
                setpoint_hi <= i_reg_wdata[1:0];
            end
            if (wr_lo)
            begin
                setpoint <= new_setpoint;
            end
            if (wr_freq)
            begin
                res_freq <= i_reg_wdata;
            end
        end
    end

    // ****************************************
    // setpoint ramp
    // ****************************************
    always_ff @(posedge i_clk)
    begin
        if (i_rst || (i_ce && (load_defaults || timeout)))
        begin
            o_dac_code <= 10'h000;
            ramp_start <= 10'h000;
            ramp_step <= 7'h00;
            ramp_acc <= 20'h00000;
            ramp_busy <= 1'b0;
        end
        else if (i_ce)
        begin
            if (wr_lo)
            begin
                // a rewrite mid-ramp restarts from what is applied now
                ramp_start <= o_dac_code;
                ramp_step <= 7'h00;
                ramp_acc <= 20'h00000;
                ramp_busy <= (new_setpoint != 10'h000);
                if (new_setpoint == 10'h000)
                begin
                    o_dac_code <= 10'h000;
                end
            end
            else if (ramp_busy)
            begin
                ramp_acc <= next_acc;
                if (step_tick)
                begin
                    ramp_step <= next_step;
                    o_dac_code <= next_dac;
                    ramp_busy <= !ramp_done;
                end
            end
        end
    end

    // ****************************************
    // output stage
    // ****************************************
    // pwm period from the frequency field
    wire logic [1:0] pwm_sel = control[2:1];
    wire logic [5:0] pwm_period = (pwm_sel == 2'h0) ? coil_focus_pkg::PWM_PERIOD_0 :
        (pwm_sel == 2'h1) ? coil_focus_pkg::PWM_PERIOD_1 :
        (pwm_sel == 2'h2) ? coil_focus_pkg::PWM_PERIOD_2 : coil_focus_pkg::PWM_PERIOD_3;
    wire logic [5:0] next_pwm_cnt = (pwm_cnt >= pwm_period - 6'h01) ? 6'h00 : pwm_cnt + 6'h01;
    // on time scales with the applied code; high side first, then freewheel
    wire logic [15:0] duty_lim = o_dac_code * pwm_period;
    wire logic hs_phase = {next_pwm_cnt, 10'h000} < duty_lim;
    wire logic active = (state == coil_focus_pkg::ST_ACTIVE);
    wire logic next_hs = active && (pwm_mode ? hs_phase : 1'b1);
    wire logic next_ls = active && pwm_mode && !hs_phase;

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            pwm_cnt <= 6'h00;
            o_stage_en <= 1'b0;
            o_hs_on <= 1'b0;
            o_ls_on <= 1'b0;
            o_pwm_mode <= coil_focus_pkg::MODE_RESET;
            o_power_state <= 2'b01;
        end
        else if (i_ce)
        begin
            pwm_cnt <= next_pwm_cnt;
            o_stage_en <= active;
            o_hs_on <= next_hs;
            o_ls_on <= next_ls;
            o_pwm_mode <= pwm_mode;
            o_power_state <= state;
        end
    end

    // ****************************************
    // register read back
    // ****************************************
    wire logic [7:0] status_word = {3'h0, sync_b[3:1], ramp_busy, active};
    wire logic [7:0] rd_mux = (i_reg_addr == coil_focus_pkg::ADDR_CONTROL) ? {4'h0, control[2:1],
        control[0], 1'b0} :
        (i_reg_addr == coil_focus_pkg::ADDR_SETPOINT_HI) ? {6'h00, setpoint[9:8]} :
        (i_reg_addr == coil_focus_pkg::ADDR_SETPOINT_LO) ? setpoint[7:0] :
        (i_reg_addr == coil_focus_pkg::ADDR_STATUS) ? status_word :
        (i_reg_addr == coil_focus_pkg::ADDR_MODE) ? {7'h00, pwm_mode} :
        (i_reg_addr == coil_focus_pkg::ADDR_RES_FREQ) ? res_freq : 8'h00;

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_reg_rdata <= 8'h00;
        end
        else if (i_ce)
        begin
            o_reg_rdata <= rd_mux;
        end
    end

endmodule

// ===== logic/coil_focus_pkg.sv
// constants, register map and types for the focus coil drive control
package coil_focus_pkg;

    // ****************************************
    // clock and timing
    // ****************************************
    localparam int CLK_KHZ = 20000;
    localparam int SCL_TIMEOUT_US = 500;
    localparam int SCL_TIMEOUT_CYCLES = SCL_TIMEOUT_US * CLK_KHZ / 1000;
    localparam int PWM_KHZ_0 = 500;
    localparam int PWM_KHZ_1 = 1000;
    localparam int PWM_KHZ_2 = 2000;
    localparam int PWM_KHZ_3 = 4000;
    localparam logic [5:0] PWM_PERIOD_0 = 6'(CLK_KHZ / PWM_KHZ_0);
    localparam logic [5:0] PWM_PERIOD_1 = 6'(CLK_KHZ / PWM_KHZ_1);
    localparam logic [5:0] PWM_PERIOD_2 = 6'(CLK_KHZ / PWM_KHZ_2);
    localparam logic [5:0] PWM_PERIOD_3 = 6'(CLK_KHZ / PWM_KHZ_3);
    // ramp runs in fixed steps; step pace comes from a frequency accumulator
    localparam int RAMP_STEP_BITS = 6;
    localparam logic [6:0] RAMP_STEPS = 7'h40;
    localparam logic [19:0] RAMP_THRESH_1P = 20'(CLK_KHZ * 1000 / 64);
    localparam logic [19:0] RAMP_THRESH_2P = 20'(2 * CLK_KHZ * 1000 / 64);
    localparam logic [7:0] RES_BASE_HZ = 8'h32;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] ADDR_CONTROL = 8'h02;
    localparam logic [7:0] ADDR_SETPOINT_HI = 8'h03;
    localparam logic [7:0] ADDR_SETPOINT_LO = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h05;
    localparam logic [7:0] ADDR_MODE = 8'h06;
    localparam logic [7:0] ADDR_RES_FREQ = 8'h07;
    localparam int CTRL_SOFT_RESET_BIT = 0;
    localparam int CTRL_TWO_PERIOD_BIT = 1;
    localparam int CTRL_PWM_SEL_LSB = 2;
    localparam int MODE_PWM_BIT = 0;
    localparam logic [2:0] CONTROL_RESET = 3'h0;
    localparam logic MODE_RESET = 1'b0;
    localparam logic [9:0] SETPOINT_RESET = 10'h000;
    localparam logic [7:0] RES_FREQ_RESET = 8'h00;

    // resonance code for 50 Hz .. 150 Hz, index is Hz minus 50
    localparam logic [7:0] RES_CODE_TABLE [0:100] = '{
        8'h00, 8'h07, 8'h0e, 8'h15, 8'h1b, 8'h22, 8'h28, 8'h2e, 8'h34, 8'h3a, 8'h3f,
        8'h44, 8'h49, 8'h4e, 8'h53, 8'h58, 8'h5c, 8'h60, 8'h65, 8'h69, 8'h6d, 8'h71,
        8'h74, 8'h78, 8'h7c, 8'h7f, 8'h82, 8'h86, 8'h89, 8'h8c, 8'h8f, 8'h92, 8'h95,
        8'h98, 8'h9a, 8'h9d, 8'ha0, 8'ha2, 8'ha5, 8'ha7, 8'haa, 8'hac, 8'hae, 8'hb1,
        8'hb3, 8'hb5, 8'hb7, 8'hb9, 8'hbb, 8'hbd, 8'hbf, 8'hc1, 8'hc3, 8'hc5, 8'hc6,
        8'hc8, 8'hca, 8'hcc, 8'hcd, 8'hcf, 8'hd0, 8'hd2, 8'hd4, 8'hd5, 8'hd7, 8'hd8,
        8'hd9, 8'hdb, 8'hdc, 8'hde, 8'hdf, 8'he0, 8'he2, 8'he3, 8'he4, 8'he5, 8'he7,
        8'he8, 8'he9, 8'hea, 8'heb, 8'hec, 8'hee, 8'hef, 8'hf0, 8'hf1, 8'hf2, 8'hf3,
        8'hf4, 8'hf5, 8'hf6, 8'hf7, 8'hf8, 8'hf9, 8'hfa, 8'hfb, 8'hfb, 8'hfc, 8'hfd,
        8'hfe, 8'hff
    };

    typedef enum logic [1:0] {
        ST_SHUTDOWN = 2'b00,
        ST_STANDBY = 2'b01,
        ST_ACTIVE = 2'b10
    } power_state_t;

endpackage

// ===== testbench/coil_focus_monitor.sv
// concurrent checks on the focus coil drive control ports
`timescale 1ns/100ps

module coil_focus_monitor #(
    parameter int SCL_TIMEOUT_CYC = 20
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_scl,
    input wire logic i_overtemp_fault,
    input wire logic i_coil_short_fault,
    input wire logic i_coil_open_fault,
    input wire logic [1:0] o_power_state,
    input wire logic o_stage_en,
    input wire logic o_pwm_mode,
    input wire logic o_hs_on,
    input wire logic o_ls_on,
    input wire logic [9:0] o_dac_code
);
    int low_cnt;
    wire active = (o_power_state == 2'b10);

    // raw low run of the clock line; saturates so a long shutdown cannot wrap it
    always_ff @(posedge i_clk)
    begin
        if (i_rst || i_scl || !i_ce)
            low_cnt <= 0;
        else if (low_cnt < SCL_TIMEOUT_CYC + 100)
            low_cnt <= low_cnt + 1;
    end

    // ****************************************
    // properties
    // ****************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // runs long enough to cover the two-flop synchroniser delay
    sequence scl_low_run; !i_scl [*5]; endsequence
    sequence scl_high_run; i_scl [*2]; endsequence
    sequence lin_steady; (active && !o_pwm_mode) [*3]; endsequence
    sequence idle_steady; (!active) [*2]; endsequence

    a_shutdown_on_timeout: assert property (low_cnt >= SCL_TIMEOUT_CYC + 6 |->
        o_power_state == 2'b00) else $error("no shutdown after clock line timeout");
    a_stay_shut_down: assert property (scl_low_run ##0 o_power_state == 2'b00 |=>
        o_power_state == 2'b00) else $error("left shutdown while clock line low");
    a_wake_to_standby: assert property (o_power_state == 2'b00 ##0 scl_high_run |->
        ##[1:6] o_power_state == 2'b01) else $error("no standby after clock line rise");
    a_stage_tracks_state: assert property (o_stage_en == active)
        else $error("stage enable differs from active state");
    a_idle_no_drive: assert property (idle_steady |-> !o_hs_on && !o_ls_on)
        else $error("switch driven outside active");
    a_linear_high_side: assert property (lin_steady |-> o_hs_on && !o_ls_on)
        else $error("linear drive not holding high side");
    a_switch_exclusive: assert property (!(o_hs_on && o_ls_on))
        else $error("high and low side on together");
    a_ramp_not_step: assert property (active && $changed(o_dac_code) |=>
        $stable(o_dac_code)) else $error("applied code stepped on back to back cycles");
    a_fault_to_standby: assert property ((i_overtemp_fault || i_coil_short_fault ||
        i_coil_open_fault) && active |-> ##[1:6] o_power_state == 2'b01)
        else $error("fault did not force standby");
endmodule

bind coil_focus_drive_control coil_focus_monitor #(.SCL_TIMEOUT_CYC(SCL_TIMEOUT_CYC))
    coil_focus_monitor_inst (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_scl(i_scl),
    .i_overtemp_fault(i_overtemp_fault), .i_coil_short_fault(i_coil_short_fault),
    .i_coil_open_fault(i_coil_open_fault), .o_power_state(o_power_state),
    .o_stage_en(o_stage_en), .o_pwm_mode(o_pwm_mode), .o_hs_on(o_hs_on),
    .o_ls_on(o_ls_on), .o_dac_code(o_dac_code));

// ===== testbench/coil_host_model.sv
// host side model: clock line level, write strobes and register reads
`timescale 1ns/100ps

module coil_host_model (
    input wire logic i_clk,
    input wire logic [7:0] i_rdata,
    output logic o_scl,
    output logic o_wr,
    output logic [7:0] o_addr,
    output logic [7:0] o_wdata
);
    // idle bus: clock line held high by its pull-up, no strobe
    initial
    begin
        o_scl = 1'b1;
        o_wr = 1'b0;
        o_addr = 8'h00;
        o_wdata = 8'h00;
    end

    // one write: strobe lasts one edge, data is scrambled once no longer qualified
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_wr <= 1'b1;
        o_addr <= a;
        o_wdata <= d;
        @(posedge i_clk);
        o_wr <= 1'b0;
        o_wdata <= ~d;
    endtask

    // read data is registered, so it is taken just after the following edge
    task automatic read(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clk);
        o_addr <= a;
        @(posedge i_clk);
        #1;
        d = i_rdata;
    endtask

    // level change of the clock line, used for shutdown and wake
    task automatic set_scl(input logic v);
        @(posedge i_clk);
        o_scl <= v;
    endtask
endmodule

// ===== testbench/tb.sv
// self-checking bench with a behavioural register and state model
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin fail_count++; \
    $display("unexpected %s: expected %h, seen %h", nm, ex, got); end end

module tb;
    localparam int TMO = 20;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_ce = 1'b1;
    logic [2:0] flt = 3'h0;
    logic scl, wr, stage_en, pwm_mode, hs_on, ls_on;
    logic [7:0] addr, wdata, rdata, rd;
    logic [1:0] o_power_state;
    logic [9:0] dac;
    int fail_count = 0;
    int n_tests = 0;
    int cycles = 0;
    integer seed = 32'h0dfe;
    int mreg[8];
    int per[4] = '{40, 20, 10, 5};
    int mset, mstage, mstate, sp, n, ls_seen, d0, exp_n;
    // resonance codes and the frequencies the lookup gives them
    int rc[3] = '{'h00, 'h3f, 'hff};
    int rhz[3] = '{50, 60, 150};

    coil_focus_drive_control #(.SCL_TIMEOUT_CYC(TMO)) coil_focus_drive_control_inst (
        .i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_scl(scl),
        .i_overtemp_fault(flt[0]), .i_coil_short_fault(flt[1]), .i_coil_open_fault(flt[2]),
        .i_reg_wr(wr), .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
        .o_power_state(o_power_state), .o_stage_en(stage_en), .o_pwm_mode(pwm_mode),
        .o_hs_on(hs_on), .o_ls_on(ls_on), .o_dac_code(dac));
    coil_host_model coil_host_model_inst (.i_clk(i_clk), .i_rdata(rdata), .o_scl(scl),
        .o_wr(wr), .o_addr(addr), .o_wdata(wdata));

    // clock and a watchdog well above the twenty-odd thousand cycles the run needs
    always #25 i_clk = ~i_clk;
    always @(posedge i_clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            fail_count++;
            test_done();
        end
    end

    // ****************************************
    // model and shared tasks
    // ****************************************
    task automatic test_done();
        $display("checks %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic settle(input int k);
        repeat (k) @(posedge i_clk);
        #1;
    endtask
    task automatic mdef();
        foreach (mreg[i]) mreg[i] = 0;
        mset = 0;
        mstage = 0;
        mstate = 1;
    endtask
    // the high byte is only staged; the low byte commits the setpoint
    task automatic wr_reg(input int a, input int d);
        coil_host_model_inst.write(8'(a), 8'(d));
        if (a == 2 && d[0])
            mdef();
        else if (a == 3)
            mstage = d & 3;
        else if (a == 4)
        begin
            mset = mstage * 256 + d;
            mstate = (mset != 0) ? 2 : 1;
        end
        else if (a == 2 || a == 6 || a == 7)
            mreg[a] = d & ((a == 2) ? 'he : (a == 6) ? 1 : 'hff);
    endtask
    task automatic rd_chk(input int a);
        int e;
        coil_host_model_inst.read(8'(a), rd);
        e = (a == 3) ? mset >> 8 : (a == 4) ? mset & 'hff : (a < 8 && a != 5) ? mreg[a] : 0;
        `CHK("register", 8'(e), rd)
    endtask
    task automatic st_chk();
        `CHK("state", 2'(mstate), o_power_state)
        `CHK("stage", 1'(mstate == 2), stage_en)
    endtask
    // cycles from one high side turn-on to the next; the first turn-on only starts the count
    task automatic pwm_period();
        int k;
        int seen;
        k = 1;
        seen = 0;
        n = 0;
        ls_seen = 0;
        do
        begin
            settle(1);
            n++;
            if (hs_on === 1'b1 && k == 0)
            begin
                seen++;
                if (seen == 2)
                begin
                    break;
                end
                n = 0;
                ls_seen = 0;
            end
            ls_seen |= int'(ls_on === 1'b1);
            k = int'(hs_on === 1'b1);
        end
        while (n < 200);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    initial
    begin
        mdef();
        repeat (6) @(posedge i_clk);
        i_rst <= 1'b0;
        settle(1);
        st_chk();
        foreach (per[i]) rd_chk(i + 2);
        rd_chk(8'h1f);
        wr_reg(7, $random(seed) & 'hff);
        rd_chk(7);
        wr_reg(7, 'hff);
        sp = 'h200 | ($random(seed) & 'h1ff);
        wr_reg(3, sp >> 8);
        wr_reg(4, sp & 'hff);
        settle(3);
        st_chk();
        `CHK("high side", 1'b1, hs_on & ~ls_on)
        `CHK("ramp start", 10'h000, dac)
        settle(4500);
        `CHK("ramp moving", 1'b1, 1'(dac > 0 && dac < sp))
        // a write made while the clock enable is low must not land
        @(posedge i_clk);
        i_ce <= 1'b0;
        coil_host_model_inst.write(8'h07, 8'h33);
        i_ce <= 1'b1;
        rd_chk(7);
        d0 = dac;
        wr_reg(3, 3);
        wr_reg(4, 'hff);
        settle(1);
        `CHK("ramp restart", 10'(d0), dac)
        wr_reg(6, 1);
        settle(3);
        `CHK("pwm mode", 1'b1, pwm_mode)
        for (int s = 0; s < 4; s++)
        begin
            wr_reg(2, s << 2);
            rd_chk(2);
            settle(50);
            pwm_period();
            `CHK("pwm period", 8'(per[s]), 8'(n))
            `CHK("freewheel", 1, ls_seen)
        end
        wr_reg(3, 0);
        wr_reg(4, 0);
        settle(3);
        st_chk();
        `CHK("zero code", 10'h000, dac)
        for (int f = 0; f < 3; f++)
        begin
            wr_reg(7, 'h5a);
            wr_reg(3, 1);
            wr_reg(4, f + 1);
            settle(3);
            st_chk();
            @(posedge i_clk);
            flt <= 3'(1 << f);
            settle(8);
            flt <= 3'h0;
            mdef();
            st_chk();
            rd_chk(4);
        end
        wr_reg(7, 'h55);
        wr_reg(3, 2);
        wr_reg(4, 'h34);
        wr_reg(2, 1);
        settle(3);
        st_chk();
        rd_chk(7);
        // step pace from the resonance code, one and two period ramps
        for (int i = 0; i < 3; i++)
        begin
            wr_reg(2, (i / 2) << 1);
            wr_reg(7, rc[i]);
            wr_reg(3, 3);
            wr_reg(4, 'hff);
            d0 = dac;
            exp_n = (20000000 * (1 + i / 2) + 64 * rhz[i] - 1) / (64 * rhz[i]);
            n = 0;
            do
            begin
                settle(1);
                n++;
            end
            while (dac === 10'(d0) && n < 12000);
            `CHK("step time", exp_n, n)
        end
        wr_reg(7, 'haa);
        coil_host_model_inst.set_scl(1'b0);
        settle(TMO + 8);
        `CHK("shutdown", 2'h0, o_power_state)
        coil_host_model_inst.write(8'h04, 8'h11);
        settle(50);
        `CHK("held shutdown", 2'h0, o_power_state)
        coil_host_model_inst.set_scl(1'b1);
        settle(6);
        mdef();
        st_chk();
        rd_chk(7);
        test_done();
    end
endmodule
